// >>> src/sld_pkg.sv
// Purpose: Shared constants and types for the serial lane control block
// Assumes: APB register access, 32-bit data, one aligned word per register
// Notes: Register offsets are byte addresses
package sld_pkg;
  localparam logic [7:0] OFF_COMMON = 8'h00;
  localparam logic [7:0] OFF_DES = 8'h04;
  localparam logic [7:0] OFF_IB = 8'h08;
  localparam logic [7:0] OFF_OB = 8'h0C;
  localparam logic [7:0] OFF_SER = 8'h10;
  localparam logic [7:0] OFF_STATUS = 8'h14;
  localparam logic [7:0] OFF_COEF = 8'h18;
  localparam logic [7:0] OFF_PHASE = 8'h1C;

  localparam logic [2:0] TC_RESET = 3'h5;
  localparam logic [2:0] BW_RESET = 3'h5;
  localparam logic [2:0] LIM_RESET = 3'h4;
  localparam logic [6:0] CENTER_BASE = 7'h40;
  localparam logic [6:0] AMP_BASE = 7'h40;
  localparam logic [5:0] LEVEL_RESET = 6'h00;
  localparam int PHASE_W = 16;
  localparam int INTEG_W = 12;
  localparam logic [3:0] PROP_SHIFT_BASE = 4'h0;
  localparam logic [PHASE_W-1:0] DEADLOCK_NUDGE = 16'h0001;

  typedef struct packed {
    logic own_recovered_clock_select;
    logic shared_recovered_clock_select;
    logic own_clock_squelch_enable;
    logic shared_clock_squelch_enable;
    logic half_speed_select;
    logic quarter_speed_select;
    logic facility_loopback_enable;
  } sld_common_t;

  typedef struct packed {
    logic [2:0] integrator_limit_control;
    logic [2:0] integrator_time_constant;
    logic [2:0] proportional_bandwidth_setting;
    logic deadlock_protection_control;
  } sld_des_t;

  typedef struct packed {
    logic input_common_mode_term_enable;
    logic [2:0] level_detect_threshold;
    logic input_low_rate_fibre_mode;
    logic offset_comp_ac_enable;
    logic offset_comp_dc_enable;
  } sld_ib_t;

  typedef struct packed {
    logic output_low_supply_mode;
    logic [5:0] first_postcursor_coefficient;
    logic center_tap_polarity;
    logic [5:0] output_amplitude_level;
    logic output_skew_adjust_enable;
    logic output_idle_enable;
    logic slew_coarse_setting;
    logic [3:0] slew_fine_setting;
  } sld_ob_t;

  typedef struct packed {
    logic serializer_phase_align_enable;
    logic [4:0] precursor_coefficient;
    logic [4:0] second_postcursor_coefficient;
  } sld_ser_t;

  typedef struct packed {
    logic [5:0] center_tap;
    logic center_neg;
    logic [6:0] amplitude_k;
  } sld_coef_t;
endpackage

// >>> src/sld_lane_ctrl.sv
// Purpose: Digital control of one multi-rate serial lane: recovered clock
//   routing with squelch, PI phase regulator, tap and amplitude derivation,
//   facility loopback and serializer phase alignment
// Assumes: APB slave on clock; lane data and phase detector on same clock
// Notes: Analog-facing settings leave as registered outputs, except skew_adjust_active and ser_align_source_loop, ANDs of registered fields
//
// The APB register port and the placing of the registers were decided locally.
`timescale 1ns/100ps
module sld_lane_ctrl
  import sld_pkg::*;
#(
  parameter int DATA_W = 10
)
(
  // Clock, reset, enable
  input wire logic clock,
  input wire logic rst_n,
  input wire logic clk_en,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Recovered clock and PCS status
  input wire logic recovered_clock,
  input wire logic pcs_data_valid,
  output logic own_recovered_clock_out,
  output logic shared_recovered_clock_out,
  output logic shared_recovered_clock_oe,
  // Deserializer phase loop
  input wire logic signed [1:0] phase_error,
  output logic [PHASE_W-1:0] sample_phase,
  // Parallel data paths
  input wire logic [DATA_W-1:0] des_data,
  input wire logic [DATA_W-1:0] pcs_tx_data,
  output logic [DATA_W-1:0] ser_data,
  output logic ser_align_enable,
  output logic ser_align_source_loop,
  // Analog configuration
  output sld_ib_t ib_cfg,
  output sld_ob_t ob_cfg,
  output sld_ser_t ser_cfg,
  output sld_coef_t coef,
  output logic skew_adjust_active
);
  sld_common_t common, next_common;
  sld_des_t des, next_des;
  sld_ib_t ib, next_ib;
  sld_ob_t ob, next_ob;
  sld_ser_t ser, next_ser;
  logic signed [INTEG_W-1:0] integ, next_integ;
  logic [15:0] integ_cnt, next_integ_cnt;
  logic [PHASE_W-1:0] phase, next_phase;
  sld_coef_t next_coef;
  logic [DATA_W-1:0] next_ser_data;
  logic [2:0] valid_sync, next_valid_sync;
  logic valid_stable, next_valid_stable;
  logic wr_en, rd_en, addr_ok;
  logic [31:0] next_prdata;

  assign wr_en = psel & penable & pwrite & clk_en;
  assign rd_en = psel & ~penable & ~pwrite;
  assign pready = clk_en;
  always_comb
  begin
    unique case (paddr)
      OFF_COMMON, OFF_DES, OFF_IB, OFF_OB, OFF_SER, OFF_STATUS, OFF_COEF, OFF_PHASE:
        addr_ok = 1'b1;
      default:
        addr_ok = 1'b0;
    endcase
  end
  assign pslverr = psel & penable & ~addr_ok;

  // Register writes; fields hold until rewritten
  always_comb
  begin
    next_common = common;
    next_des = des;
    next_ib = ib;
    next_ob = ob;
    next_ser = ser;
    if (wr_en)
    begin
      unique case (paddr)
        OFF_COMMON: next_common = sld_common_t'(pwdata[6:0]);
        OFF_DES: next_des = sld_des_t'(pwdata[9:0]);
        OFF_IB: next_ib = sld_ib_t'(pwdata[6:0]);
        OFF_OB: next_ob = sld_ob_t'(pwdata[20:0]);
        OFF_SER: next_ser = sld_ser_t'(pwdata[10:0]);
        default: ;
      endcase
    end
  end

  // Read data registered in the setup cycle so it stands through access
  always_comb
  begin
    next_prdata = prdata;
    if (rd_en)
    begin
      unique case (paddr)
        OFF_COMMON: next_prdata = {25'h0000000, common};
        OFF_DES: next_prdata = {22'h000000, des};
        OFF_IB: next_prdata = {25'h0000000, ib};
        OFF_OB: next_prdata = {11'h000, ob};
        OFF_SER: next_prdata = {21'h000000, ser};
        OFF_STATUS: next_prdata = {31'h00000000, valid_stable};
        OFF_COEF: next_prdata = {18'h00000, coef};
        OFF_PHASE: next_prdata = {phase, 4'h0, integ};
        default: next_prdata = 32'h00000000;
      endcase
    end
  end

  // PCS valid is a pin: three stages, change taken when stages two and three agree
  always_comb
  begin
    next_valid_sync = {valid_sync[1:0], pcs_data_valid};
    next_valid_stable = valid_stable;
    if (valid_sync[1] == valid_sync[2])
      next_valid_stable = valid_sync[2];
  end

  // Recovered clock is a pass-through; squelch gates it glitch-free enough
  // only because the valid level changes slowly relative to the clock
  always_comb
  begin
    own_recovered_clock_out = common.own_recovered_clock_select & recovered_clock
      & ~(common.own_clock_squelch_enable & ~valid_stable);
    shared_recovered_clock_oe = common.shared_recovered_clock_select;
    shared_recovered_clock_out = shared_recovered_clock_oe & recovered_clock
      & ~(common.shared_clock_squelch_enable & ~valid_stable);
  end

  // PI regulator: integrator stepped on a nonzero error once 2^(tc+8-bw) cycles have been counted
  logic [4:0] integ_shift;
  logic signed [INTEG_W-1:0] integ_lim;
  logic signed [PHASE_W-1:0] prop_step, integ_ext, nudge;
  always_comb
  begin
    integ_shift = 5'(des.integrator_time_constant) + 5'd1
      - 5'(des.proportional_bandwidth_setting) + 5'd7;
    integ_lim = INTEG_W'(signed'({1'b0, 8'hFF} >> (3'd7 - des.integrator_limit_control)));
    next_integ = integ;
    next_integ_cnt = integ_cnt + 16'd1;
    if (phase_error != 2'sd0 && integ_cnt >= (16'd1 << integ_shift[3:0]))
    begin
      next_integ_cnt = 16'h0000;
      // Step by one LSB; at the exact offset this toggles between two values
      if (phase_error > 0 && integ < integ_lim)
        next_integ = integ + INTEG_W'(1);
      else if (phase_error < 0 && integ > -integ_lim)
        next_integ = integ - INTEG_W'(1);
    end
    // Wider setting number halves proportional gain and trackable offset
    prop_step = PHASE_W'(signed'(phase_error)) <<< (4'd8
      - {1'b0, des.proportional_bandwidth_setting} + PROP_SHIFT_BASE);
    integ_ext = PHASE_W'(integ);
    nudge = des.deadlock_protection_control ? DEADLOCK_NUDGE : '0;
    next_phase = phase + PHASE_W'(prop_step + integ_ext + nudge);
  end

  // Coefficient derivation
  logic [6:0] mag_sum;
  always_comb
  begin
    mag_sum = 7'(ser.precursor_coefficient[3:0])
      + 7'(ob.first_postcursor_coefficient[4:0])
      + 7'(ser.second_postcursor_coefficient[3:0]);
    next_coef.center_tap = 6'(CENTER_BASE - mag_sum);
    next_coef.center_neg = ob.center_tap_polarity;
    next_coef.amplitude_k = AMP_BASE + 7'(ob.output_amplitude_level);
  end

  // Facility loopback sends deserialized data back out
  always_comb
  begin
    next_ser_data = common.facility_loopback_enable ? des_data : pcs_tx_data;
  end

  // Configuration fields; supply mode comes up in the safe 1.2V setting
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      common <= '0;
      des <= '{LIM_RESET, TC_RESET, BW_RESET, 1'b0};
      ib <= '0;
      ob <= '{1'b0, 6'h00, 1'b1, LEVEL_RESET, 1'b0, 1'b0, 1'b0, 4'h0};
      ser <= '0;
    end
    else if (clk_en)
    begin
      common <= next_common;
      des <= next_des;
      ib <= next_ib;
      ob <= next_ob;
      ser <= next_ser;
    end
  end

  // Read data
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      prdata <= '0;
    end
    else if (clk_en)
    begin
      prdata <= next_prdata;
    end
  end

  // PCS valid synchroniser
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      valid_sync <= '0;
      valid_stable <= 1'b0;
    end
    else if (clk_en)
    begin
      valid_sync <= next_valid_sync;
      valid_stable <= next_valid_stable;
    end
  end

  // Phase regulator state; frozen with the rest when the enable is low
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      integ <= '0;
      integ_cnt <= '0;
      phase <= '0;
    end
    else if (clk_en)
    begin
      integ <= next_integ;
      integ_cnt <= next_integ_cnt;
      phase <= next_phase;
    end
  end

  // Derived coefficients
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      coef <= '0;
    end
    else if (clk_en)
    begin
      coef <= next_coef;
    end
  end

  // Serializer data
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ser_data <= '0;
    end
    else if (clk_en)
    begin
      ser_data <= next_ser_data;
    end
  end

  assign sample_phase = phase;
  assign ib_cfg = ib;
  assign ob_cfg = ob;
  assign ser_cfg = ser;
  assign ser_align_enable = ser.serializer_phase_align_enable;
  assign ser_align_source_loop = ser.serializer_phase_align_enable
    & common.facility_loopback_enable;
  // Skew only at 1 Gbps (quarter rate) SGMII
  assign skew_adjust_active = ob.output_skew_adjust_enable
    & common.quarter_speed_select & ~common.half_speed_select;
endmodule

// >>> verif/sld_lane_checker.sv
// Purpose: Port-level assertions for the lane control block
// Assumes: Single clock domain, async active-low reset
// Notes: Coefficient outputs lag their settings by one cycle
`timescale 1ns/100ps
module sld_lane_checker
  import sld_pkg::*;
#(
  parameter int DATA_W = 10
)
(
  // Watched ports
  input wire logic clock,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic recovered_clock,
  input wire logic own_recovered_clock_out,
  input wire logic shared_recovered_clock_out,
  input wire logic shared_recovered_clock_oe,
  input wire logic [DATA_W-1:0] des_data,
  input wire logic [DATA_W-1:0] ser_data,
  input wire logic ser_align_source_loop,
  input wire sld_ob_t ob_cfg,
  input wire sld_ser_t ser_cfg,
  input wire sld_coef_t coef,
  input wire logic skew_adjust_active
);
  logic [6:0] mag_sum;
  // Signs are dropped: only magnitudes reduce the centre tap
  assign mag_sum = {3'h0, ser_cfg.precursor_coefficient[3:0]}
    + {2'h0, ob_cfg.first_postcursor_coefficient[4:0]}
    + {3'h0, ser_cfg.second_postcursor_coefficient[3:0]};
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  property p_own_gate;
    own_recovered_clock_out |-> recovered_clock;
  endproperty
  a_own_gate: assert property (p_own_gate) else $error("own clock high without source");
  property p_shared_gate;
    shared_recovered_clock_out |-> shared_recovered_clock_oe && recovered_clock;
  endproperty
  a_shared_gate: assert property (p_shared_gate) else $error("shared clock not gated");
  property p_center;
    $past(mag_sum) != 7'h00 |-> coef.center_tap == 6'(7'h40 - $past(mag_sum));
  endproperty
  a_center: assert property (p_center) else $error("centre tap magnitude wrong");
  property p_center_sign;
    $past(rst_n) |-> coef.center_neg == $past(ob_cfg.center_tap_polarity);
  endproperty
  a_center_sign: assert property (p_center_sign) else $error("centre tap sign wrong");
  property p_amp;
    $past(rst_n) |-> coef.amplitude_k == {1'b0, $past(ob_cfg.output_amplitude_level)} + 7'h40;
  endproperty
  a_amp: assert property (p_amp) else $error("amplitude coefficient wrong");
  property p_skew;
    skew_adjust_active |-> ob_cfg.output_skew_adjust_enable;
  endproperty
  a_skew: assert property (p_skew) else $error("skew active while disabled");
  property p_loop;
    $past(ser_align_source_loop && clk_en && rst_n) |-> ser_data == $past(des_data);
  endproperty
  a_loop: assert property (p_loop) else $error("loopback data not returned");
  property p_hold;
    $past(rst_n) && !$past(psel && penable && pwrite) |-> $stable(ob_cfg) && $stable(ser_cfg);
  endproperty
  a_hold: assert property (p_hold) else $error("settings changed without write");
endmodule
bind sld_lane_ctrl sld_lane_checker #(.DATA_W(DATA_W)) u_chk (.clock, .rst_n, .clk_en, .psel,
  .penable, .pwrite, .recovered_clock, .own_recovered_clock_out, .shared_recovered_clock_out,
  .shared_recovered_clock_oe, .des_data, .ser_data, .ser_align_source_loop, .ob_cfg, .ser_cfg,
  .coef, .skew_adjust_active);

// >>> verif/sld_far_model.sv
// Purpose: Remote transceiver and PCS status seen by the lane
// Assumes: Phase detector result is pushed in by the bench
// Notes: Recovered clock runs unrelated to the system clock
`timescale 1ns/100ps
module sld_far_model #(
  parameter int DATA_W = 10
)
(
  // Clock and control
  input wire logic clock,
  input wire logic link_ok,
  input wire logic signed [1:0] phase_push,
  // Lane side
  output logic recovered_clock,
  output logic pcs_data_valid,
  output logic signed [1:0] phase_error,
  output logic [DATA_W-1:0] des_data
);
  initial
  begin
    recovered_clock = 1'b0;
    // Odd offset keeps its edges off every system clock edge, so sampling never races
    #0.1;
    forever #3.2 recovered_clock = ~recovered_clock;
  end
  initial des_data = '0;
  // Changing word every cycle so a stale loopback is caught
  always @(posedge clock) des_data <= des_data + DATA_W'(7);
  assign pcs_data_valid = link_ok;
  assign phase_error = phase_push;
endmodule

// >>> verif/sld_lane_ctrl_tb.sv
// Purpose: Register-driven tests of the lane control block
// Assumes: Zero-wait APB slave, clk_en held high
// Notes: Expected values worked out from field layout
`timescale 1ns/100ps
module sld_lane_ctrl_tb;
  import sld_pkg::*;
  logic clock = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, link_ok = 1;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, rc, pv, own_o, sh_o, sh_oe, al_en, al_loop, skew, ep;
  logic signed [1:0] pe;
  logic signed [1:0] push = 2'sb00;
  logic [9:0] dd, ser_data, tx = 10'h155, d;
  logic [15:0] ph, p0, s5, s6;
  sld_ib_t ib;
  sld_ob_t ob;
  sld_ser_t sc;
  sld_coef_t cf;
  int error_cnt = 0, comparisons = 0;
  `define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin error_cnt++; \
    $display("unexpected at %0t: got %h exp %h", $time, a, b); end end
  sld_far_model far (.clock(clock), .link_ok(link_ok), .phase_push(push), .recovered_clock(rc),
    .pcs_data_valid(pv), .phase_error(pe), .des_data(dd));
  sld_lane_ctrl uut (.clock(clock), .rst_n(rst_n), .clk_en(1'b1), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .recovered_clock(rc), .pcs_data_valid(pv), .own_recovered_clock_out(own_o),
    .shared_recovered_clock_out(sh_o), .shared_recovered_clock_oe(sh_oe), .phase_error(pe),
    .sample_phase(ph), .des_data(dd), .pcs_tx_data(tx), .ser_data(ser_data),
    .ser_align_enable(al_en), .ser_align_source_loop(al_loop), .ib_cfg(ib), .ob_cfg(ob),
    .ser_cfg(sc), .coef(cf), .skew_adjust_active(skew));
  initial forever #4 clock = ~clock;
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clock);
    penable <= 1'b1;
    do @(posedge clock); while (pready !== 1'b1);
    rd = prdata;
    ep = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // One-cycle phase detector pulse; returns the phase step it caused
  task automatic kick(output logic [15:0] step);
    @(posedge clock);
    push <= 2'sb01;
    #1 p0 = ph;
    @(posedge clock);
    push <= 2'sb00;
    #1 step = ph - p0;
  endtask
  task automatic close_out();
    if (error_cnt == 0 && comparisons > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial
  begin
    repeat (20000) @(posedge clock);
    error_cnt++;
    close_out();
  end
  initial
  begin
    repeat (5) @(posedge clock);
    rst_n <= 1'b1;
    apb(0, OFF_DES, 0);
    `CHK(rd, 32'h0000025A)
    apb(0, OFF_OB, 0);
    `CHK(rd, 32'h00002000)
    `CHK(ob.output_low_supply_mode, 1'b0)
    apb(1, OFF_IB, 32'h00000003); // AC coupled, not fibre rate, offset comp on
    #1 `CHK(ib, 7'h03)
    apb(1, OFF_SER, 32'h000006E3); // Align on, prec -7, post2 +3
    apb(1, OFF_OB, 32'h000ABF80); // Post1 -10, polarity 1, level 63
    @(posedge clock);
    #1 `CHK(cf.center_tap, 6'h2C)
    `CHK(cf.center_neg, 1'b1)
    `CHK(cf.amplitude_k, 7'h7F)
    `CHK(al_en, 1'b1)
    apb(1, OFF_COMMON, 32'h00000078); // Both outputs squelched; only lane on shared
    repeat (3) @(negedge clock) `CHK({own_o, sh_o}, {rc, rc})
    @(posedge clock) link_ok <= 1'b0;
    repeat (6) @(posedge clock);
    repeat (3) @(negedge clock) `CHK({own_o, sh_o}, 2'b00)
    @(posedge clock) link_ok <= 1'b1;
    apb(1, OFF_COMMON, 32'h00000022); // Shared output, quarter rate
    #1 `CHK(sh_oe, 1'b1)
    apb(1, OFF_OB, 32'h00002040); // Skew adjust on
    #1 `CHK(skew, 1'b1)
    apb(1, OFF_COMMON, 32'h00000004); // Half rate
    #1 `CHK(skew, 1'b0)
    `CHK(ser_data, 10'h155)
    apb(1, OFF_COMMON, 32'h00000001);
    #1 `CHK(al_loop, 1'b1)
    repeat (2) @(posedge clock);
    #1 d = dd;
    @(posedge clock);
    #1 `CHK(ser_data, d)
    apb(1, OFF_DES, 32'h0000025B); // Recommended settings, deadlock guard on
    @(posedge clock);
    #1 p0 = ph;
    @(posedge clock);
    #1 `CHK(ph, p0 + 16'h0001)
    apb(1, OFF_DES, 32'h0000027A); // Slow integrator, bandwidth 5, guard off
    kick(s5);
    apb(1, OFF_DES, 32'h0000027C); // Bandwidth 6
    kick(s6);
    `CHK(s5, {s6[14:0], 1'b0})
    `CHK(s6 != 16'h0000, 1'b1)
    apb(0, 8'h40, 0);
    `CHK(ep, 1'b1)
    `CHK(rd, 32'h00000000)
    close_out();
  end
endmodule
